//--- pkg/bcdfs_pkg.sv
/*
  Shared constants for the BCD field-select, port 10 and interrupt block:
  register offsets, field layouts, field codes and the record slot map.
  Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
*/
package bcdfs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] ADDR_ID     = 8'h00;
  localparam logic [7:0] ADDR_INTR   = 8'h04;
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_FIELD  = 8'h0C;
  localparam logic [7:0] ADDR_DATA   = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_ERROR  = 8'h18;

  // value is arbitrary
  localparam logic [7:0] ID_VALUE = 8'h5A;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control, config and switch bank register bits
  localparam int CTRL_IO_A  = 7;
  localparam int CTRL_IO_B  = 6;
  localparam int CTRL_CTL_A = 5;
  localparam int CTRL_CTL_B = 4;
  localparam int CFG_TWO_FA = 0;
  localparam int CFG_TWO_FB = 1;
  localparam int CFG_P10_OUT = 2;
  localparam int SW_OUT_EN  = 7;

  // field select command word
  localparam logic [6:0] FIELD_MAX = 7'h06;
  localparam logic [2:0] OP_LAST   = 3'h5;
  localparam logic [2:0] FIELD_ALL  = 3'h0;
  localparam logic [2:0] FIELD_A    = 3'h1;
  localparam logic [2:0] FIELD_B    = 3'h2;
  localparam logic [2:0] FIELD_A_ME = 3'h3;
  localparam logic [2:0] FIELD_B_ME = 3'h4;
  localparam logic [2:0] FIELD_A_FN = 3'h5;
  localparam logic [2:0] FIELD_B_FN = 3'h6;

  // record: per channel 4 mantissa, 1 exponent, up to 2 function digits
  localparam int CH_SLOTS  = 7;
  localparam int SLOTS     = 14;
  localparam int ME_SLOTS  = 5;
  localparam int SLOT_FMSD = 5;
  localparam logic [3:0] SLOT_NONE = 4'hF;

  function automatic logic [13:0] field_mask(input logic [2:0] f,
                                             input logic       two_a,
                                             input logic       two_b);
    logic a_me;
    logic a_fn;
    logic b_me;
    logic b_fn;
    a_me = f == FIELD_ALL || f == FIELD_A || f == FIELD_A_ME;
    a_fn = f == FIELD_ALL || f == FIELD_A || f == FIELD_A_FN;
    b_me = f == FIELD_ALL || f == FIELD_B || f == FIELD_B_ME;
    b_fn = f == FIELD_ALL || f == FIELD_B || f == FIELD_B_FN;
    return {two_b & b_fn, b_fn, {ME_SLOTS{b_me}},
            two_a & a_fn, a_fn, {ME_SLOTS{a_me}}};
  endfunction : field_mask

endpackage : bcdfs_pkg

//--- design/bcdfs_field_seq.sv
/*
  Readout pointer over the captured record: walks the enabled slots in
  record order and wraps after the last one.
  Assumes pop and restart are one-cycle pulses from the same clock.
*/
module bcdfs_field_seq
  import bcdfs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [SLOTS-1:0]  mask,
  input  wire logic              pop,
  input  wire logic              restart,
  output logic      [3:0]        slot,
  output logic                   last
);

  typedef struct packed {
    logic [3:0] ptr;
  } bcdfs_seq_t;

  bcdfs_seq_t st;
  bcdfs_seq_t next_st;

  // smallest enabled slot above p, else the first enabled slot
  function automatic logic [3:0] next_slot(input logic [SLOTS-1:0] m,
                                           input logic [3:0]       p);
    logic [3:0] r;
    r = p;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 4'(i);
      end
    end
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (m[i] && 4'(i) > p) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : next_slot

  always_comb begin
    next_st = st;
    if (restart) begin
      next_st.ptr = next_slot(mask, SLOT_NONE);
    end else if (pop) begin
      next_st.ptr = next_slot(mask, st.ptr);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign slot = st.ptr;
  assign last = next_slot(mask, st.ptr) <= st.ptr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  pop_order_a: assert property (pop && !restart && mask != '0 |=>
    mask[st.ptr] && (st.ptr > $past(st.ptr) || $past(last)))
    else $error("readout skipped or reordered a field");

endmodule : bcdfs_field_seq

//--- design/bcdfs_top.sv
/*
  BCD instrument card core: partial field selection of the input record,
  the 4-bit auxiliary port 10, and interrupts from the function MSDs.
  Assumes an AXI4-Lite master on clk and instrument pins that are
  asynchronous; digits are stable while a channel flag rises.
*/
// Our own choices: the address map and the AXI4-Lite register port.
//
// Function
// - full record order: A mantissa, A function, B...
// - later field only after all earlier read
// - field addresses 00..06 accepted, 00 whole record
// - 01 channel A fields, 02 channel B fields
// - 03/04 mantissa+exponent, 05/06 function only
// - field stays latched until rewritten or reset
// - remote addressing 00..06 also loads field
// - every addressing operation kind loads the field; here only kinds 0..5 do, 6 and 7 leave it
// - port 10 works as input or output
// - port 10 drives without the switch enable
// - port 10 out from control low nibble
// - only function MSDs raise interrupts
// - single function digit counts as MSD
// - interrupt only for bits enabled in mask
// - no further interrupt until serviced; here only a mask write re-arms, a cause read does not
// - several enabled bits reported together
// - mask 128 selects channel B MSD bit 3
// - cause register shows interrupting bits
// - output direction refused without switch, error
module bcdfs_top
  import bcdfs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [DATA_W-1:0] rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [27:0]       inst_a_digits,
  input  wire logic [27:0]       inst_b_digits,
  input  wire logic              inst_a_flag,
  input  wire logic              inst_b_flag,
  input  wire logic [7:0]        default_config_switch_bank,
  input  wire logic [3:0]        p10_in,
  output logic      [3:0]        p10_out,
  output logic      [3:0]        p10_oe,
  output logic                   ch_a_out_en,
  output logic                   ch_b_out_en,
  output logic                   ctl_a,
  output logic                   ctl_b,
  output logic                   irq
);

  localparam int PIN_W = 70;

  typedef struct packed {
    logic [PIN_W-1:0]  s1;
    logic [PIN_W-1:0]  s2;
    logic              flag_a_d;
    logic              flag_b_d;
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [2:0]        field;
    logic [7:0]        mask;
    logic [7:0]        cause;
    logic              armed;
    logic              irq;
    logic              io_a;
    logic              io_b;
    logic              ctl_a;
    logic              ctl_b;
    logic [3:0]        p10;
    logic [2:0]        cfg;
    logic              err113;
    logic [27:0]       snap_a;
    logic [27:0]       snap_b;
  } bcdfs_state_t;

  bcdfs_state_t st;
  bcdfs_state_t next_st;

  logic [7:0]       sw;
  logic [3:0]       p10_pin;
  logic             flag_a;
  logic             flag_b;
  logic [27:0]      dig_a;
  logic [27:0]      dig_b;
  logic             cap_a;
  logic             cap_b;
  logic [7:0]       new_bits;
  logic             wr_do;
  logic             rd_take;
  logic             fld_load;
  logic             restart;
  logic             pop;
  logic [SLOTS-1:0] mask_seq;
  logic [3:0]       slot;
  logic             last;
  logic [55:0]      snap;
  logic [3:0]       digit;

  ////////////////////////////////////////////////////////////////////////
  // pin side: only the second synchroniser stage is read

  assign {sw, p10_pin, flag_b, flag_a, dig_b, dig_a} = st.s2;
  assign cap_a = flag_a && !st.flag_a_d;
  assign cap_b = flag_b && !st.flag_b_d;

  // only the function MSD slot is looked at, whatever the digit count
  assign new_bits = {
    cap_b ? dig_b[SLOT_FMSD*4 +: 4] : 4'h0,
    cap_a ? dig_a[SLOT_FMSD*4 +: 4] : 4'h0} & st.mask;

  ////////////////////////////////////////////////////////////////////////
  // record readout

  assign snap = {st.snap_b, st.snap_a};
  assign digit = snap[{slot, 2'b00} +: 4];
  // a field load restarts on the layout it selects, not the one it replaces
  assign mask_seq = field_mask(fld_load ? st.wdata[2:0] : st.field,
                               st.cfg[CFG_TWO_FA],
                               st.cfg[CFG_TWO_FB]);

  assign wr_do = st.aw_held && st.w_held && !st.bvalid;
  assign rd_take = arvalid && st.arready;
  assign pop = rd_take && araddr == ADDR_DATA;
  // unknown addresses and operation kinds leave the latched field alone
  assign fld_load = wr_do && st.awaddr == ADDR_FIELD && &st.wstrb[1:0]
    && st.wdata[6:0] <= FIELD_MAX && st.wdata[10:8] <= OP_LAST;
  // restarting on a layout change avoids pointing at a dropped slot
  assign restart = fld_load || (wr_do && st.awaddr == ADDR_CONFIG
                                && st.wstrb[0]);

  bcdfs_field_seq u_seq (
    .clk     (clk),
    .reset_n (reset_n),
    .mask    (mask_seq),
    .pop     (pop),
    .restart (restart),
    .slot    (slot),
    .last    (last)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.s1 = {default_config_switch_bank, p10_in, inst_b_flag,
                  inst_a_flag, inst_b_digits, inst_a_digits};
    next_st.s2 = st.s1;
    next_st.flag_a_d = flag_a;
    next_st.flag_b_d = flag_b;
    if (cap_a) begin
      next_st.snap_a = dig_a;
    end
    if (cap_b) begin
      next_st.snap_b = dig_b;
    end

    // write channel: address and data taken in either order
    if (awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end

    // servicing: reading the cause clears it
    if (rd_take && araddr == ADDR_INTR) begin
      next_st.cause = 8'h00;
      next_st.irq = 1'b0;
    end
    // a new event wins over the clear in the same cycle
    if (st.armed && new_bits != 8'h00) begin
      next_st.cause = next_st.cause | new_bits;
      next_st.irq = 1'b1;
      next_st.armed = 1'b0;
    end

    if (wr_do) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      unique case (st.awaddr)
        ADDR_INTR: begin
          if (st.wstrb[0]) begin
            next_st.mask = st.wdata[7:0];
            next_st.armed = 1'b1;
          end
        end
        ADDR_CTRL: begin
          if (st.wstrb[0]) begin
            next_st.io_a = st.wdata[CTRL_IO_A] && sw[SW_OUT_EN];
            next_st.io_b = st.wdata[CTRL_IO_B] && sw[SW_OUT_EN];
            if ((st.wdata[CTRL_IO_A] || st.wdata[CTRL_IO_B])
                && !sw[SW_OUT_EN]) begin
              next_st.err113 = 1'b1;
            end
            next_st.ctl_a = st.wdata[CTRL_CTL_A];
            next_st.ctl_b = st.wdata[CTRL_CTL_B];
            next_st.p10 = st.wdata[3:0];
          end
        end
        ADDR_FIELD: begin
          if (fld_load) begin
            next_st.field = st.wdata[2:0];
          end
        end
        ADDR_CONFIG: begin
          if (st.wstrb[0]) begin
            next_st.cfg = st.wdata[2:0];
          end
        end
        ADDR_ERROR: begin
          if (st.wstrb[0] && st.wdata[0]) begin
            next_st.err113 = 1'b0;
          end
        end
        default: begin
          next_st.bresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    // read channel: answer one cycle after the address is taken
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      unique case (araddr)
        ADDR_ID:     next_st.rdata = {24'h0, ID_VALUE};
        ADDR_INTR:   next_st.rdata = {24'h0, st.cause};
        ADDR_CTRL:   next_st.rdata = {24'h0, st.io_a, st.io_b, st.ctl_a,
                                      st.ctl_b, flag_a, flag_b, 2'b00};
        ADDR_FIELD:  next_st.rdata = {29'h0, st.field};
        ADDR_DATA:   next_st.rdata = {23'h0, last, slot, digit};
        ADDR_CONFIG: next_st.rdata = {8'h0, st.mask, 4'h0, p10_pin,
                                      5'h0, st.cfg};
        ADDR_ERROR:  next_st.rdata = {31'h0, st.err113};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign p10_out = st.p10;
  assign p10_oe = {4{st.cfg[CFG_P10_OUT]}};
  assign ch_a_out_en = st.io_a;
  assign ch_b_out_en = st.io_b;
  assign ctl_a = st.ctl_a;
  assign ctl_b = st.ctl_b;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  field_latch_a: assert property ($changed(st.field) |-> $past(fld_load))
    else $error("field changed without a field load");

  field_range_a: assert property (st.field <= FIELD_B_FN)
    else $error("field selector out of range");

  irq_armed_a: assert property ($rose(st.irq) |-> $past(st.armed)
    && !st.armed) else $error("interrupt raised while blocked");

  cause_masked_a: assert property (
    ((st.cause & ~$past(st.cause)) & ~$past(st.mask)) == 8'h00)
    else $error("cause bit set for a masked bit");

  p10_write_a: assert property (wr_do && st.awaddr == ADDR_CTRL
    && st.wstrb[0] |=> p10_out == $past(st.wdata[3:0]))
    else $error("port 10 did not follow control write");

  dir_refuse_a: assert property (wr_do && st.awaddr == ADDR_CTRL
    && st.wstrb[0] && st.wdata[CTRL_IO_A] && !sw[SW_OUT_EN]
    |=> !ch_a_out_en && st.err113)
    else $error("output direction taken without switch enable");

  irq_service_a: assert property (rd_take && araddr == ADDR_INTR
    && !st.armed |=> !irq ##1 !irq) else $error("cause read kept request");

  read_answer_a: assert property (rd_take |=> rvalid
    && ($past(araddr) != ADDR_INTR || rdata[7:0] == $past(st.cause)))
    else $error("read answer late or wrong");

endmodule : bcdfs_top

//--- verification/bcdfs_inst_model.sv
/*
  Behavioural BCD instrument: presents a 7-slot digit word and pulses its
  flag so the card captures it.
  Assumes the caller supplies a free-running clk; digits settle before the
  flag rises and hold well past the card's two-flop synchroniser.
*/
module bcdfs_inst_model (
  input  wire logic        clk,
  output logic      [27:0] digits,
  output logic             flag
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    digits = 28'h0000000;
    flag   = 1'h0;
  end

  // slow stretches set-up and the flag pulse, not the hold, as a sluggish meter would
  task automatic send(input logic [27:0] d, input int slow = 0);
    @(posedge clk);
    digits <= d;
    repeat (4 + slow) @(posedge clk);
    flag <= 1'h1;
    repeat (4 + slow) @(posedge clk);
    flag <= 1'h0;
    repeat (4) @(posedge clk);
    // hold time over: show garbage, not the old reading
    digits <= ~d;
  endtask : send

endmodule : bcdfs_inst_model

//--- verification/bcdfs_tb.sv
/*
  Self-checking bench for the field select, port 10 and interrupt core.
  Assumes bcdfs_pkg and two instrument models; registers are reached by an
  AXI4-Lite master built from tasks below.
*/
module bcdfs_tb
  import bcdfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk = 1'h0;
  logic              reset_n = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [3:0]        wstrb = 4'h0;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic              arvalid = 1'h0, rready = 1'h0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  logic [27:0]       a_digits, b_digits;
  logic              a_flag, b_flag;
  logic [7:0]        sw = 8'h00;
  logic [3:0]        p10_in = 4'hA;
  logic [3:0]        p10_out, p10_oe;
  logic              ch_a_out_en, ch_b_out_en, ctl_a, ctl_b;
  logic [55:0]       rec = {28'hEDCBA98, 28'h7654321};
  int                n_fail = 0;
  int                compares = 0;

  always #25 clk = ~clk;

  bcdfs_top bcdfs_top_i (
    .clk(clk), .reset_n(reset_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .inst_a_digits(a_digits), .inst_b_digits(b_digits),
    .inst_a_flag(a_flag), .inst_b_flag(b_flag),
    .default_config_switch_bank(sw), .p10_in(p10_in),
    .p10_out(p10_out), .p10_oe(p10_oe),
    .ch_a_out_en(ch_a_out_en), .ch_b_out_en(ch_b_out_en),
    .ctl_a(ctl_a), .ctl_b(ctl_b), .irq(irq)
  );
  bcdfs_inst_model bcdfs_inst_model_a_i (
    .clk(clk), .digits(a_digits), .flag(a_flag)
  );
  bcdfs_inst_model bcdfs_inst_model_b_i (
    .clk(clk), .digits(b_digits), .flag(b_flag)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = 4'hF);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // is slot s part of field f under function-count config c
  function automatic logic en(input int f, input int s, input int c);
    int ch;
    int k;
    ch = s / 7;
    k  = s % 7;
    if (k == 6 && c[ch] == 1'h0) return 1'h0;
    if (k < 5) return f == 0 || f == 1 + ch || f == 3 + ch;
    return f == 0 || f == 1 + ch || f == 5 + ch;
  endfunction : en

  //////////////////////////////////////////////////////////////////////////
  initial begin
    int top;
    int first;
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    rd(ADDR_ID, {24'h0, ID_VALUE});
    rd(ADDR_FIELD, 32'h0);
    wr(ADDR_ID, 32'h1, RESP_SLVERR);
    rd(8'h1C, 32'h0, RESP_SLVERR);
    bcdfs_inst_model_a_i.send(rec[27:0]);
    bcdfs_inst_model_b_i.send(rec[55:28], 20);
    for (int c = 0; c < 4; c += 3) begin
      wr(ADDR_CONFIG, 32'(c));
      for (int f = 0; f < 7; f++) begin
        wr(ADDR_FIELD, {21'h0, 3'(f % 6), 1'h0, 7'(f)});
        rd(ADDR_FIELD, 32'(f));
        first = 99;
        for (int s = 0; s < 14; s++) begin
          if (en(f, s, c)) top = s;
          if (en(f, s, c) && first == 99) first = s;
        end
        for (int s = 0; s < 14; s++) begin
          if (en(f, s, c))
            rd(ADDR_DATA, {23'h0, s == top, 4'(s), rec[4*s +: 4]});
        end
        // a second pass must use the same latched field
        rd(ADDR_DATA, {23'h0, first == top, 4'(first), rec[4*first +: 4]});
      end
    end
    wr(ADDR_FIELD, 32'h00000007);
    rd(ADDR_FIELD, 32'h6);
    wr(ADDR_FIELD, 32'h00000601);
    rd(ADDR_FIELD, 32'h6);
    // a field write needs both low byte lanes
    wr(ADDR_FIELD, 32'h00000002, RESP_OKAY, 4'h1);
    rd(ADDR_FIELD, 32'h6);

    wr(ADDR_CONFIG, 32'h4);
    wr(ADDR_CTRL, 32'hCF);
    check({28'h0, p10_out}, 32'hF);
    check({28'h0, p10_oe}, 32'hF);
    check({30'h0, ch_a_out_en, ch_b_out_en}, 32'h0);
    rd(ADDR_ERROR, 32'h1);
    rd(ADDR_CONFIG, 32'hA04);
    @(posedge clk);
    sw <= 8'h80;
    repeat (3) @(posedge clk);
    wr(ADDR_ERROR, 32'h1);
    rd(ADDR_ERROR, 32'h0);
    wr(ADDR_CTRL, 32'hF5);
    check({24'h0, ch_a_out_en, ch_b_out_en, ctl_a, ctl_b, p10_out}, 32'hF5);
    rd(ADDR_CTRL, 32'hF0);
    wr(ADDR_CONFIG, 32'h1);
    check({28'h0, p10_oe}, 32'h0);
    p10_in <= 4'h5;
    repeat (3) @(posedge clk);
    rd(ADDR_CONFIG, 32'h501);

    wr(ADDR_INTR, 32'h0F);
    bcdfs_inst_model_a_i.send(28'hF054321);
    check({31'h0, irq}, 32'h0);
    bcdfs_inst_model_a_i.send(28'h0954321);
    check({31'h0, irq}, 32'h1);
    bcdfs_inst_model_a_i.send(28'h0154321);
    rd(ADDR_INTR, 32'h09);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bcdfs_inst_model_a_i.send(28'h0154321);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_INTR, 32'h80);
    bcdfs_inst_model_a_i.send(28'h0F54321);
    check({31'h0, irq}, 32'h0);
    wr(ADDR_CONFIG, 32'h0);
    bcdfs_inst_model_b_i.send(28'h0854321);
    check({31'h0, irq}, 32'h1);
    rd(ADDR_INTR, 32'h80);
    // a mid-run reset drops the latched field and the mask
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    rd(ADDR_FIELD, 32'h0);
    rd(ADDR_CONFIG, 32'h500);
    check({31'h0, irq}, 32'h0);
    wrap_up();
  end

  // a hung handshake ends the run with a failure
  initial begin
    #(20000 * 50);
    n_fail++;
    wrap_up();
  end

endmodule : bcdfs_tb
